/* rtl/tick_pkg.sv */
// Package of register map, field layout and reset values for the tick counter
package tick_pkg;
	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [31:0] OFS_STATUS_CONTROL = 32'h0000_0000;
	localparam logic [31:0] OFS_COUNT_VALUE = 32'h0000_0004;
	localparam logic [31:0] OFS_MATCH_LIMIT = 32'h0000_0008;

	// ****************************************************************
	// Status/control field positions
	// ****************************************************************
	localparam int FLAG_BIT = 7;
	localparam int SRC_HI = 6;
	localparam int SRC_LO = 5;
	localparam int IE_BIT = 4;
	localparam int PS_HI = 3;
	localparam int PS_LO = 0;

	// ****************************************************************
	// Reset values and encodings
	// ****************************************************************
	localparam logic [1:0] SRC_RESET = 2'h0;
	localparam logic [3:0] PS_RESET = 4'h0;
	localparam logic [7:0] LIMIT_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [1:0] SRC_LOW_POWER = 2'h0;
	localparam int PRE_W = 18;
	localparam logic [17:0] PRE_RESET = 18'h00000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SEL_CTRL,
		SEL_COUNT,
		SEL_LIMIT,
		SEL_NONE
	} reg_sel_t;
endpackage

/* rtl/periodic_tick_counter.sv */
// Periodic tick counter with prescaler, match flag and AXI4-Lite registers
`timescale 1ns/1ps

module periodic_tick_counter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic low_power_osc_clock,
	input wire logic external_ref_clock,
	input wire logic internal_ref_clock,
	input wire logic stop2_mode,
	input wire logic background_debug_active,
	output logic irq
);
	import tick_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic reg_sel_t decode(input logic [31:0] addr);
		if (addr == OFS_STATUS_CONTROL) begin
			decode = SEL_CTRL;
		end else if (addr == OFS_COUNT_VALUE) begin
			decode = SEL_COUNT;
		end else if (addr == OFS_MATCH_LIMIT) begin
			decode = SEL_LIMIT;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	// Divide ratio; zero means prescaler off
	function automatic logic [17:0] ratio(input logic s0,
			input logic [3:0] ps);
		logic [17:0] r;
		r = 18'h00000;
		if (!s0) begin
			case (ps)
				4'h1: r = 18'h00008;
				4'h2: r = 18'h00020;
				4'h3: r = 18'h00040;
				4'h4: r = 18'h00080;
				4'h5: r = 18'h00100;
				4'h6: r = 18'h00200;
				4'h7: r = 18'h00400;
				4'h8: r = 18'h00001;
				4'h9: r = 18'h00002;
				4'hA: r = 18'h00004;
				4'hB: r = 18'h0000A;
				4'hC: r = 18'h00010;
				4'hD: r = 18'h00064;
				4'hE: r = 18'h001F4;
				4'hF: r = 18'h003E8;
				default: r = 18'h00000;
			endcase
		end else begin
			case (ps)
				4'h1: r = 18'h00400;
				4'h2: r = 18'h00800;
				4'h3: r = 18'h01000;
				4'h4: r = 18'h02000;
				4'h5: r = 18'h04000;
				4'h6: r = 18'h08000;
				4'h7: r = 18'h10000;
				4'h8: r = 18'h003E8;
				4'h9: r = 18'h007D0;
				4'hA: r = 18'h01388;
				4'hB: r = 18'h02710;
				4'hC: r = 18'h04E20;
				4'hD: r = 18'h0C350;
				4'hE: r = 18'h186A0;
				4'hF: r = 18'h30D40;
				default: r = 18'h00000;
			endcase
		end
		ratio = r;
	endfunction

	// ****************************************************************
	// Tick source synchronisers
	// ****************************************************************
	logic [2:0] src_meta_q;
	logic [2:0] src_sync_q;
	logic [2:0] src_prev_q;
	logic [2:0] src_edge;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_meta_q <= 3'h0;
			src_sync_q <= 3'h0;
			src_prev_q <= 3'h0;
		end else begin
			src_meta_q <= {internal_ref_clock, external_ref_clock,
				low_power_osc_clock};
			src_sync_q <= src_meta_q;
			src_prev_q <= src_sync_q;
		end
	end

	assign src_edge = src_sync_q & ~src_prev_q;

	// ****************************************************************
	// Bus and register state
	// ****************************************************************
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [31:0] waddr_q, waddr_d, wdat_q, wdat_d;
	logic wstrb0_q, wstrb0_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic flag_q, flag_d, ie_q, ie_d, irq_q, irq_d;
	logic [1:0] src_q, src_d;
	logic [3:0] ps_q, ps_d;
	logic [7:0] limit_q, limit_d, count_q, count_d;
	logic [17:0] pre_q, pre_d;
	logic do_write, clear_counters, tick_edge, pre_tick, match_event;
	logic [17:0] cur_ratio;
	logic [7:0] ctrl_view;
	reg_sel_t wsel;

	assign ctrl_view = {flag_q, src_q, ie_q, ps_q};

	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		waddr_d = waddr_q;
		wdat_d = wdat_q;
		wstrb0_d = wstrb0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		flag_d = flag_q;
		ie_d = ie_q;
		src_d = src_q;
		ps_d = ps_q;
		limit_d = limit_q;
		count_d = count_q;
		pre_d = pre_q;
		clear_counters = 1'b0;
		match_event = 1'b0;
		pre_tick = 1'b0;

		// Write address and data taken in either order
		if (awvalid && awready_q) begin
			aw_held_d = 1'b1;
			waddr_d = awaddr;
		end
		if (wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdat_d = wdata;
			wstrb0_d = wstrb[0];
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		do_write = aw_held_q && w_held_q && !bvalid_q;
		wsel = decode(waddr_q);
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (wstrb0_q && wsel == SEL_CTRL) begin
				if (wdat_q[FLAG_BIT]) begin
					flag_d = 1'b0;
				end
				ie_d = wdat_q[IE_BIT];
				src_d = wdat_q[SRC_HI:SRC_LO];
				ps_d = wdat_q[PS_HI:PS_LO];
				if (wdat_q[SRC_HI:SRC_LO] != src_q) begin
					clear_counters = 1'b1;
				end
				if (wdat_q[PS_HI:PS_LO] != ps_q) begin
					clear_counters = 1'b1;
				end
			end else if (wstrb0_q && wsel == SEL_LIMIT) begin
				limit_d = wdat_q[7:0];
				clear_counters = 1'b1;
			end
			// Writes to the count register have no effect
		end

		// Read channel
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			case (decode(araddr))
				SEL_CTRL: rdata_d = {24'h000000, ctrl_view};
				SEL_COUNT: rdata_d = {24'h000000, count_q};
				SEL_LIMIT: rdata_d = {24'h000000, limit_q};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end

		// Source mux: 00 low-power, 01 external, 1x internal
		case (src_q)
			2'h0: tick_edge = src_edge[0];
			2'h1: tick_edge = src_edge[1];
			default: tick_edge = src_edge[2];
		endcase
		// Only the low-power source runs in stop2
		if (stop2_mode && src_q != SRC_LOW_POWER) begin
			tick_edge = 1'b0;
		end
		// Debug freeze holds every counter
		if (background_debug_active) begin
			tick_edge = 1'b0;
		end

		// Wait and stop modes other than stop2 do not gate counting
		cur_ratio = ratio(src_q[0], ps_q);
		if (cur_ratio != PRE_RESET && tick_edge) begin
			if (pre_q == cur_ratio - 18'h00001) begin
				pre_d = PRE_RESET;
				pre_tick = 1'b1;
			end else begin
				pre_d = pre_q + 18'h00001;
			end
		end
		if (pre_tick) begin
			if (count_q == limit_q) begin
				count_d = COUNT_RESET;
				match_event = 1'b1;
			end else begin
				count_d = count_q + 8'h01;
			end
		end
		if (clear_counters) begin
			pre_d = PRE_RESET;
			count_d = COUNT_RESET;
		end
		// A counter clear in the same cycle blocks setting the flag
		if (match_event && !clear_counters) begin
			flag_d = 1'b1;
		end

		awready_d = !aw_held_d && !bvalid_d;
		wready_d = !w_held_d && !bvalid_d;
		arready_d = !rvalid_d;
		irq_d = flag_d && ie_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			waddr_q <= 32'h0000_0000;
			wdat_q <= 32'h0000_0000;
			wstrb0_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			flag_q <= 1'b0;
			ie_q <= 1'b0;
			src_q <= SRC_RESET;
			ps_q <= PS_RESET;
			limit_q <= LIMIT_RESET;
			count_q <= COUNT_RESET;
			pre_q <= PRE_RESET;
			irq_q <= 1'b0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			waddr_q <= waddr_d;
			wdat_q <= wdat_d;
			wstrb0_q <= wstrb0_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			flag_q <= flag_d;
			ie_q <= ie_d;
			src_q <= src_d;
			ps_q <= ps_d;
			limit_q <= limit_d;
			count_q <= count_d;
			pre_q <= pre_d;
			irq_q <= irq_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;
	assign irq = irq_q;
endmodule

/* bench/tick_counter_asserts.sv */
// Port checker for the periodic tick counter
`timescale 1ns/1ps
module tick_counter_asserts
	import tick_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic background_debug_active,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	chk_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	chk_read_latency: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_ar_blocked: assert property (rvalid |-> !arready)
		else $error("read address taken while busy");
	chk_count_width: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	chk_unmapped_read: assert property (arvalid && arready &&
		araddr > OFS_MATCH_LIMIT |=> rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_irq_frozen: assert property ($rose(irq) && !$rose(bvalid) |->
		!$past(background_debug_active))
		else $error("interrupt raised while frozen");
	chk_irq_clear: assert property ($fell(irq) |-> $rose(bvalid))
		else $error("interrupt fell without write");
	chk_irq_reset: assert property ($rose(aresetn) |-> !irq)
		else $error("interrupt high after reset");
endmodule

bind periodic_tick_counter tick_counter_asserts u_tick_counter_asserts (
	.aclk, .aresetn, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.rready, .bresp, .bvalid, .bready, .background_debug_active, .irq);

/* bench/tb.sv */
// Register-level testbench for the periodic tick counter
`timescale 1ns/1ps
module tb;
	import tick_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] pins = 3'h0;
	logic stop2_mode = 1'h0, background_debug_active = 1'h0;
	int miscompares = 0;
	int cmp_count = 0;
	always #20 aclk = ~aclk;
	periodic_tick_counter u_periodic_tick_counter (.aclk, .aresetn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .low_power_osc_clock(pins[0]),
		.external_ref_clock(pins[1]), .internal_ref_clock(pins[2]),
		.stop2_mode, .background_debug_active, .irq);
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task end_of_test;
		if (miscompares == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	task timeout;
		miscompares++;
		$display("MISMATCH %0t no answer", $time);
		end_of_test();
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		if (i == 50) timeout();
		chk(32'(bresp), 32'(er));
	endtask
	task rc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
		if (i == 50) timeout();
		chk(rdata, e);
		chk(32'(rresp), 32'(er));
	endtask
	// Source edges spaced well above the synchroniser minimum
	task pulse(input logic [2:0] m, input int n);
		repeat (n) begin
			@(posedge aclk);
			pins <= m;
			repeat (4) @(posedge aclk);
			pins <= 3'h0;
			repeat (3) @(posedge aclk);
		end
		repeat (4) @(posedge aclk);
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rc(OFS_STATUS_CONTROL, 32'h0, RESP_OKAY);
		rc(OFS_MATCH_LIMIT, 32'h0, RESP_OKAY);
		pulse(3'h7, 1);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		rc(32'h10, 32'h0, RESP_SLVERR);
		wr(32'h10, 32'h1, RESP_SLVERR);
		wr(OFS_MATCH_LIMIT, 32'h3, RESP_OKAY);
		wr(OFS_STATUS_CONTROL, 32'h18, RESP_OKAY);
		pulse(3'h6, 2);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		pulse(3'h1, 3);
		rc(OFS_COUNT_VALUE, 32'h3, RESP_OKAY);
		wr(OFS_COUNT_VALUE, 32'h55, RESP_OKAY);
		rc(OFS_COUNT_VALUE, 32'h3, RESP_OKAY);
		chk(32'(irq), 32'h0);
		pulse(3'h1, 1);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		rc(OFS_STATUS_CONTROL, 32'h98, RESP_OKAY);
		chk(32'(irq), 32'h1);
		wr(OFS_STATUS_CONTROL, 32'h08, RESP_OKAY);
		chk(32'(irq), 32'h0);
		rc(OFS_STATUS_CONTROL, 32'h88, RESP_OKAY);
		wr(OFS_STATUS_CONTROL, 32'h88, RESP_OKAY);
		rc(OFS_STATUS_CONTROL, 32'h08, RESP_OKAY);
		pulse(3'h1, 2);
		background_debug_active <= 1'h1;
		pulse(3'h1, 2);
		rc(OFS_COUNT_VALUE, 32'h2, RESP_OKAY);
		background_debug_active <= 1'h0;
		pulse(3'h1, 1);
		rc(OFS_COUNT_VALUE, 32'h3, RESP_OKAY);
		wr(OFS_STATUS_CONTROL, 32'h09, RESP_OKAY);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		pulse(3'h1, 3);
		rc(OFS_COUNT_VALUE, 32'h1, RESP_OKAY);
		wr(OFS_STATUS_CONTROL, 32'h48, RESP_OKAY);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		stop2_mode <= 1'h1;
		pulse(3'h4, 2);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		stop2_mode <= 1'h0;
		pulse(3'h4, 2);
		rc(OFS_COUNT_VALUE, 32'h2, RESP_OKAY);
		wr(OFS_MATCH_LIMIT, 32'h0, RESP_OKAY);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		pulse(3'h4, 1);
		rc(OFS_STATUS_CONTROL, 32'hC8, RESP_OKAY);
		wr(OFS_MATCH_LIMIT, 32'h5, RESP_OKAY);
		wr(OFS_STATUS_CONTROL, 32'hA8, RESP_OKAY);
		rc(OFS_STATUS_CONTROL, 32'h28, RESP_OKAY);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		pulse(3'h2, 999);
		rc(OFS_COUNT_VALUE, 32'h0, RESP_OKAY);
		pulse(3'h2, 1);
		rc(OFS_COUNT_VALUE, 32'h1, RESP_OKAY);
		end_of_test();
	end
endmodule
